// [logic/i2m_pkg.sv]
// Summary of operation
// - Busy flag, status bit 7, is set while the interface runs; transmit FIFO drains then.
// - Missing slave acknowledge sets status bit 6 and stops; software writes zero to clear.
// - Status bit 5 is set while the receive FIFO holds a byte; zero clears.
// - Status bit 4 is set when the transmit FIFO goes empty; zero clears.
// - Two-bit level of the active FIFO: 00 empty, 10 half, 11 full, 01 reserved.
// - Status bit 1 is set on a simultaneous write and read; zero clears.
// - Status bit 0 is set on a transmit write into a full FIFO; zero clears.
// - Target address bit 0 selects read from or write to the slave.
// - During reads the master acknowledges each received byte except the last by itself.
// - After the programmed byte count the master sends a not-acknowledge.
// - Address rewritten mid-transfer gives a repeated start instead of a stop.
// - Separate receive and transmit FIFOs of four bytes each.
// - Software may preload four transmit bytes before shifting starts.
// - Transmit FIFO empty when the shifter needs a byte ends the transfer.
// - A write transfer error ends it and flushes the transmit FIFO.
// - Receive FIFO holds four bytes before software must read them.
// - A read stops once the received count reaches the programmed count plus one.
// - Serial clock is core clock over 16, 32, 64 or 128 by rate code.
// - Five-bit receive count: a read ends after count plus one bytes.
// - With the enable set, writing the target address starts a transfer.
package i2m_pkg;

  localparam logic [7:0] ADR_TX = 8'h9a;
  localparam logic [7:0] ADR_RX = 8'h9b;
  localparam logic [7:0] ADR_MODE = 8'he8;
  localparam logic [7:0] ADR_TGT = 8'he9;
  localparam logic [7:0] ADR_STAT = 8'hea;

  localparam int ST_BUSY = 7;
  localparam int ST_NOACK = 6;
  localparam int ST_RXNE = 5;
  localparam int ST_TXE = 4;
  localparam int ST_ACCERR = 1;
  localparam int ST_TXOVF = 0;
  localparam int MD_EN = 7;
  localparam int MD_RATE_HI = 6;
  localparam int MD_RATE_LO = 5;
  localparam int MD_RCT_HI = 4;
  localparam int TGT_RW = 0;

  localparam logic [1:0] LVL_EMPTY = 2'h0;
  localparam logic [1:0] LVL_RSVD = 2'h1;
  localparam logic [1:0] LVL_HALF = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Quarter bit period in core cycles at rate code 00 (divide by 16).
  localparam logic [5:0] QTR_BASE = 6'h04;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] PH_LOW = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_BITS = 4'h4,
    ST_STOP = 4'h8
  } i2m_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } i2m_sfr_req_t;

endpackage : i2m_pkg

// [logic/i2m_master.sv]
`timescale 1ns/10ps
`default_nettype none

// Small flip-flop FIFO with valid and ready on both sides.
module i2m_fifo #(
  parameter int W = 8,
  parameter int D = 4,
  parameter int CW = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [CW-1:0] count_o
);
  logic [W-1:0] mem_q [D];
  logic [CW-2:0] wp_q;
  logic [CW-2:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != CW'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign count_o = cnt_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end

  // Storage needs no reset; the count guards every read.
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wp_q] <= in_data_i;
  end
endmodule : i2m_fifo

// Two-wire master with status flags, reached through its register port.
module i2m_master (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire i2m_pkg::i2m_sfr_req_t sfr_i,
  output logic [7:0] sfr_rdata_o,
  output logic irq_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic scl_o,
  output logic scl_oe_o
);
  localparam int CW = i2m_pkg::CNT_W;

  // Level field from a FIFO occupancy.
  function automatic logic [1:0] level(input logic [CW-1:0] c);
    if (c == '0) return i2m_pkg::LVL_EMPTY;
    else if (c == CW'(i2m_pkg::FIFO_DEPTH)) return i2m_pkg::LVL_FULL;
    else return i2m_pkg::LVL_HALF;
  endfunction : level

  i2m_pkg::i2m_state_t state_q;
  logic [7:0] mode_q;
  logic [7:0] tgt_q;
  logic [5:0] div_q;
  logic [5:0] qmax;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rxmode_q;
  logic cur_rw_q;
  logic [4:0] rx_cnt_q;
  logic ack_q;
  logic restart_q;
  logic busy_q;
  logic noack_q;
  logic rxne_q;
  logic txe_q;
  logic accerr_q;
  logic txovf_q;
  logic tx_had_q;
  logic sda_m_q;
  logic sda_s_q;
  logic wr_ok;
  logic rd_ok;
  logic tick;
  logic stall;
  logic step;
  logic byte_end;
  logic nack_ev;
  logic last_w;
  logic go;
  logic tx_push;
  logic tx_ready;
  logic tx_valid;
  logic tx_pop;
  logic tx_flush;
  logic [7:0] tx_data;
  logic [CW-1:0] tx_cnt;
  logic rx_push;
  logic rx_ready;
  logic rx_valid;
  logic rx_pop;
  logic [7:0] rx_data;
  logic [CW-1:0] rx_cnt;
  logic [1:0] lvl_d;
  logic [7:0] stat_d;
  logic scl_oe_d;
  logic sda_oe_d;
  logic stat_clr;

  // A simultaneous write and read is refused as a whole.
  assign wr_ok = sfr_i.wr && !sfr_i.rd;
  assign rd_ok = sfr_i.rd && !sfr_i.wr;
  assign tx_push = wr_ok && (sfr_i.addr == i2m_pkg::ADR_TX);
  assign rx_pop = rd_ok && (sfr_i.addr == i2m_pkg::ADR_RX);
  assign go = wr_ok && (sfr_i.addr == i2m_pkg::ADR_TGT) && mode_q[i2m_pkg::MD_EN];
  // A write to the status register can only clear flags.
  assign stat_clr = wr_ok && (sfr_i.addr == i2m_pkg::ADR_STAT);

  // Quarter period is 4, 8, 16 or 32 cycles, a quarter of 16 << rate.
  assign qmax = 6'((i2m_pkg::QTR_BASE
                    << mode_q[i2m_pkg::MD_RATE_HI:i2m_pkg::MD_RATE_LO])
                   - 1'b1);
  assign tick = (div_q == qmax);
  // Holding SCL low while the receive FIFO is full keeps bytes from being lost.
  assign stall = (state_q == i2m_pkg::ST_BITS) && rxmode_q && (bit_q == i2m_pkg::ACK_BIT)
                 && (ph_q == i2m_pkg::PH_LOW) && !rx_ready;
  assign step = tick && !stall;
  assign byte_end = step && (state_q == i2m_pkg::ST_BITS) && (ph_q == i2m_pkg::PH_FALL)
                    && (bit_q == i2m_pkg::ACK_BIT);
  assign nack_ev = byte_end && !rxmode_q && ack_q;
  assign last_w = (rx_cnt_q == mode_q[i2m_pkg::MD_RCT_HI:0]);
  assign rx_push = step && (state_q == i2m_pkg::ST_BITS) && rxmode_q
                   && (bit_q == i2m_pkg::ACK_BIT) && (ph_q == i2m_pkg::PH_LOW);
  // The shifter takes a new byte only while a write carries on.
  assign tx_pop = byte_end && !rxmode_q && !ack_q && !cur_rw_q;
  assign tx_flush = nack_ev && !cur_rw_q;

  // Transmit path: software preloads up to four bytes.
  i2m_fifo #(
    .W(i2m_pkg::DATA_W),
    .D(i2m_pkg::FIFO_DEPTH),
    .CW(CW)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .flush_i(tx_flush),
    .in_valid_i(tx_push),
    .in_ready_o(tx_ready),
    .in_data_i(sfr_i.wdata),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_pop),
    .out_data_o(tx_data),
    .count_o(tx_cnt)
  );

  // Receive path: four bytes before software must read.
  i2m_fifo #(
    .W(i2m_pkg::DATA_W),
    .D(i2m_pkg::FIFO_DEPTH),
    .CW(CW)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .flush_i(1'b0),
    .in_valid_i(rx_push),
    .in_ready_o(rx_ready),
    .in_data_i(sh_q),
    .out_valid_o(rx_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_data),
    .count_o(rx_cnt)
  );

  // SDA passes two flip-flops before the engine samples it.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  // Mode and target address registers.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= i2m_pkg::RESET_BYTE;
      tgt_q <= i2m_pkg::RESET_BYTE;
    end else if (wr_ok) begin
      if (sfr_i.addr == i2m_pkg::ADR_MODE) mode_q <= sfr_i.wdata;
      else if (sfr_i.addr == i2m_pkg::ADR_TGT) tgt_q <= sfr_i.wdata;
    end
  end

  // Quarter-period divider; it idles at zero between transfers.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) div_q <= '0;
    else if (state_q == i2m_pkg::ST_IDLE || step) div_q <= '0;
    else if (!tick) div_q <= div_q + 1'b1;
  end

  // A target rewrite while busy is remembered for a repeated start.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) restart_q <= 1'b0;
    else if (go && state_q != i2m_pkg::ST_IDLE) restart_q <= 1'b1;
    else if (state_q == i2m_pkg::ST_START) restart_q <= 1'b0;
  end

  // Bus sequencer: start, nine-bit byte slots, stop.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= i2m_pkg::ST_IDLE;
      ph_q <= i2m_pkg::PH_LOW;
      bit_q <= '0;
      sh_q <= i2m_pkg::RESET_BYTE;
      rxmode_q <= 1'b0;
      cur_rw_q <= 1'b0;
      rx_cnt_q <= '0;
      ack_q <= 1'b0;
    end else begin
      case (state_q)
        i2m_pkg::ST_IDLE: begin
          ph_q <= i2m_pkg::PH_LOW;
          if (go) state_q <= i2m_pkg::ST_START;
        end
        i2m_pkg::ST_START: begin
          if (step) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == i2m_pkg::PH_FALL) begin
              state_q <= i2m_pkg::ST_BITS;
              bit_q <= '0;
              sh_q <= tgt_q;
              cur_rw_q <= tgt_q[i2m_pkg::TGT_RW];
              rxmode_q <= 1'b0;
              rx_cnt_q <= '0;
            end
          end
        end
        i2m_pkg::ST_BITS: begin
          if (step) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == i2m_pkg::PH_SAMPLE) begin
              if (rxmode_q && bit_q != i2m_pkg::ACK_BIT) sh_q <= {sh_q[6:0], sda_s_q};
              else if (!rxmode_q && bit_q == i2m_pkg::ACK_BIT) ack_q <= sda_s_q;
            end
            if (ph_q == i2m_pkg::PH_FALL) begin
              bit_q <= bit_q + 1'b1;
              if (!rxmode_q && bit_q != i2m_pkg::ACK_BIT) sh_q <= {sh_q[6:0], 1'b0};
              if (bit_q == i2m_pkg::ACK_BIT) begin
                bit_q <= '0;
                if (rxmode_q) rx_cnt_q <= rx_cnt_q + 1'b1;
                if (nack_ev) begin
                  state_q <= i2m_pkg::ST_STOP;
                end else if (rxmode_q ? last_w : !cur_rw_q && !tx_valid) begin
                  state_q <= restart_q ? i2m_pkg::ST_START : i2m_pkg::ST_STOP;
                end else if (cur_rw_q) begin
                  rxmode_q <= 1'b1;
                end else begin
                  sh_q <= tx_data;
                end
              end
            end
          end
        end
        i2m_pkg::ST_STOP: begin
          if (step) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == i2m_pkg::PH_FALL) state_q <= i2m_pkg::ST_IDLE;
          end
        end
        default: state_q <= i2m_pkg::ST_IDLE;
      endcase
    end
  end

  // Pin levels per phase; SDA moves while SCL is high only for start and stop.
  always_comb begin
    scl_oe_d = 1'b0;
    sda_oe_d = 1'b0;
    case (state_q)
      i2m_pkg::ST_START: begin
        scl_oe_d = (ph_q == i2m_pkg::PH_LOW) || (ph_q == i2m_pkg::PH_FALL);
        sda_oe_d = ph_q[1];
      end
      i2m_pkg::ST_BITS: begin
        scl_oe_d = (ph_q == i2m_pkg::PH_LOW) || (ph_q == i2m_pkg::PH_FALL);
        if (bit_q != i2m_pkg::ACK_BIT) sda_oe_d = !rxmode_q && !sh_q[7];
        else sda_oe_d = rxmode_q && !last_w;
      end
      i2m_pkg::ST_STOP: begin
        scl_oe_d = (ph_q == i2m_pkg::PH_LOW);
        sda_oe_d = !ph_q[1];
      end
      default: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    endcase
  end

  // Open-drain pins: the data value is always low, only the enable moves.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_oe_o <= scl_oe_d;
      sda_oe_o <= sda_oe_d;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // Flags other than busy are sticky; a hardware set wins over a software clear.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
      noack_q <= 1'b0;
      rxne_q <= 1'b0;
      txe_q <= 1'b0;
      accerr_q <= 1'b0;
      txovf_q <= 1'b0;
      tx_had_q <= 1'b0;
    end else begin
      busy_q <= (state_q != i2m_pkg::ST_IDLE);
      tx_had_q <= (tx_cnt != '0);
      noack_q <= nack_ev
                 || (noack_q && !(stat_clr && !sfr_i.wdata[i2m_pkg::ST_NOACK]));
      rxne_q <= rx_valid
                || (rxne_q && !(stat_clr && !sfr_i.wdata[i2m_pkg::ST_RXNE]));
      txe_q <= (tx_had_q && tx_cnt == '0)
               || (txe_q && !(stat_clr && !sfr_i.wdata[i2m_pkg::ST_TXE]));
      accerr_q <= (sfr_i.wr && sfr_i.rd)
                  || (accerr_q
                      && !(stat_clr && !sfr_i.wdata[i2m_pkg::ST_ACCERR]));
      txovf_q <= (tx_push && !tx_ready)
                 || (txovf_q
                     && !(stat_clr && !sfr_i.wdata[i2m_pkg::ST_TXOVF]));
    end
  end

  // Level of whichever FIFO the current direction uses.
  assign lvl_d = cur_rw_q ? level(rx_cnt) : level(tx_cnt);
  assign stat_d = {busy_q, noack_q, rxne_q, txe_q, lvl_d, accerr_q, txovf_q};

  // Read data and interrupt request are registered.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= i2m_pkg::RESET_BYTE;
      irq_o <= 1'b0;
    end else begin
      irq_o <= noack_q || rxne_q || txe_q;
      if (!rd_ok) sfr_rdata_o <= sfr_rdata_o;
      else if (sfr_i.addr == i2m_pkg::ADR_RX) sfr_rdata_o <= rx_valid ? rx_data : '0;
      else if (sfr_i.addr == i2m_pkg::ADR_MODE) sfr_rdata_o <= mode_q;
      else if (sfr_i.addr == i2m_pkg::ADR_TGT) sfr_rdata_o <= tgt_q;
      else if (sfr_i.addr == i2m_pkg::ADR_STAT) sfr_rdata_o <= stat_d;
      else sfr_rdata_o <= '0;
    end
  end

  busy_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q != i2m_pkg::ST_IDLE |=> busy_q) else $error("busy flag low in transfer");
  noack_stop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    nack_ev |=> noack_q && state_q == i2m_pkg::ST_STOP) else $error("no stop on nack");
  rx_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_cnt != '0 |=> rxne_q) else $error("receive flag missing");
  tx_empty_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_cnt != '0 ##1 tx_cnt == '0 |=> txe_q) else $error("tx empty flag missing");
  level_code_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lvl_d != i2m_pkg::LVL_RSVD) else $error("reserved level code");
  acc_error_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sfr_i.wr && sfr_i.rd |=> accerr_q) else $error("access error not flagged");
  tx_overflow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_push && !tx_ready |=> txovf_q && tx_cnt == CW'(i2m_pkg::FIFO_DEPTH))
    else $error("overflow not flagged");
  master_ack_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == i2m_pkg::ST_BITS && rxmode_q && bit_q == i2m_pkg::ACK_BIT
    && ph_q == i2m_pkg::PH_SAMPLE && !last_w |-> sda_oe_o) else $error("no master ack");
  final_nack_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == i2m_pkg::ST_BITS && rxmode_q && bit_q == i2m_pkg::ACK_BIT
    && ph_q == i2m_pkg::PH_SAMPLE && last_w |-> !sda_oe_o) else $error("no final nack");
  tx_flush_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_flush |=> tx_cnt == '0) else $error("tx fifo not flushed");
endmodule : i2m_master

`default_nettype wire

// [test/i2m_slave_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Behavioural target on the two-wire bus; it never stretches the clock.
module i2m_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  input wire logic [7:0] rd_base_i,
  output logic pull_o,
  output logic [7:0] last_o,
  output logic [7:0] nbytes_o,
  output logic [7:0] hist_o,
  output logic [7:0] starts_o,
  output logic [7:0] stops_o
);
  logic active_q;
  logic first_q;
  logic rd_q;
  logic rdn_q;
  logic [3:0] slot_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] sent_q;

  // The line starts released, so the pull-up holds it high.
  initial begin
    pull_o = 1'b0;
    active_q = 1'b0;
    {last_o, nbytes_o, hist_o, starts_o, stops_o} = '0;
  end

  // Start or repeated start: data falls while the clock is high.
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      active_q = 1'b1;
      first_q = 1'b1;
      {rd_q, rdn_q, slot_q, sent_q} = '0;
      // The clock falls once more after the start, so begin one slot early.
      slot_q = 4'hf;
      pull_o = 1'b0;
      starts_o++;
    end
  end

  // Stop: data rises while the clock is high.
  // Only a started frame can stop; the release out of reset is not one.
  always @(posedge sda_i) begin
    if (scl_i === 1'b1 && active_q) begin
      active_q = 1'b0;
      pull_o = 1'b0;
      stops_o++;
    end
  end

  // Data bits shift in on the rising clock; in reads the ack slot is logged.
  always @(posedge scl_i) begin
    if (active_q && slot_q < 4'h8) begin
      sh_q = {sh_q[6:0], sda_i};
    end else if (active_q && rd_q) begin
      hist_o = {hist_o[6:0], sda_i};
    end
  end

  // Each falling clock closes a slot; the line only moves while it is low.
  always @(negedge scl_i) begin
    if (active_q && slot_q == 4'h7 && !rd_q) begin
      last_o = sh_q;
      nbytes_o++;
      pull_o = ~nack_i;
      if (first_q) begin
        rdn_q = sh_q[0];
      end
      first_q = 1'b0;
      slot_q = 4'h8;
    end else if (active_q && slot_q == 4'h8) begin
      slot_q = 4'h0;
      pull_o = 1'b0;
      // A not-acknowledge from the master ends our data; otherwise send on.
      if (rdn_q && !(rd_q && hist_o[0])) begin
        if (rd_q) begin
          sent_q++;
        end
        rd_q = 1'b1;
        tx_q = rd_base_i + sent_q;
        pull_o = ~tx_q[7];
      end
    end else if (active_q) begin
      slot_q++;
      pull_o = (rd_q && slot_q < 4'h8) ? ~tx_q[4'h7 - slot_q] : 1'b0;
    end
  end
endmodule : i2m_slave_model

`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  i2m_pkg::i2m_sfr_req_t sfr = '0;
  logic [7:0] rdata;
  logic irq, sda_o, sda_oe, scl_o, scl_oe, pull, sda_w, scl_w;
  logic nack = 1'b0;
  logic [7:0] last, nbytes, hist, starts, stops, s0, p0;
  int fail_count = 0;
  int check_count = 0;
  // Rows: write address, write data, read address, expected read data.
  logic [31:0] rows [9] = '{32'he81f_e81f, 32'h9a11_ea08, 32'h9a22_ea08,
    32'h9a33_ea08, 32'h9a44_ea0c, 32'h9a55_ea0d, 32'hea00_ea0c,
    32'h50ff_5000, 32'h5000_9b00};

  always #50 clk_i = ~clk_i;

  // Both lines are open drain with pull-ups: low while anyone pulls.
  assign sda_w = ~(sda_oe | pull);
  assign scl_w = ~scl_oe;

  i2m_master dut (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_i(sfr),
    .sfr_rdata_o(rdata), .irq_o(irq), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .scl_o(scl_o), .scl_oe_o(scl_oe));

  i2m_slave_model slv (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
    .rd_base_i(8'h5a), .pull_o(pull), .last_o(last), .nbytes_o(nbytes),
    .hist_o(hist), .starts_o(starts), .stops_o(stops));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Register strobes last one cycle, so each counts exactly once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    @(negedge clk_i);
    sfr.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr.rd = 1'b1;
    sfr.addr = a;
    @(negedge clk_i);
    sfr.rd = 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(16'(d & m), 16'(e));
  endtask : rdchk

  // Polls the status register, bounded, until the masked bits match.
  task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    d = ~v;
    for (int i = 0; i < 3000 && (d & m) !== v; i++) begin
      rd(8'hea, d);
    end
    // Running out of polls means the bus hung: count it as a mismatch.
    if ((d & m) !== v) begin
      fail_count++;
      $display("[FAIL] %0t status poll timed out", $time);
    end
  endtask : wait_stat

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // The whole run needs some five thousand cycles; this leaves margin.
  initial begin
    #(40000 * 100);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  // Main sequence: reset, table rows, then the bus scenarios.
  initial begin
    realtime t0;
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    rdchk(8'hea, 8'hff, 8'h00);
    rdchk(8'he8, 8'hff, 8'h00);
    rdchk(8'he9, 8'hff, 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rdchk(rows[i][15:8], 8'hff, rows[i][7:0]);
    end
    // Four preloaded bytes go out behind the address, then a stop.
    wr(8'he8, 8'h80);
    wr(8'he9, 8'ha0);
    rdchk(8'hea, 8'h80, 8'h80);
    wait_stat(8'h80, 8'h00);
    chk(16'(last), 16'h0044);
    chk(16'(nbytes), 16'h0005);
    chk(16'({sda_o, scl_o}), 16'h0000);
    rdchk(8'hea, 8'hff, 8'h10);
    chk(16'(irq), 16'h0001);
    wr(8'hea, 8'h00);
    rdchk(8'hea, 8'hff, 8'h00);
    // Every rate code; an empty FIFO ends each transfer after the address.
    for (int r = 0; r < 4; r++) begin
      wr(8'he8, {1'b1, 2'(r), 5'h00});
      wr(8'he9, 8'ha0);
      @(posedge scl_w);
      t0 = $realtime;
      @(posedge scl_w);
      chk(16'(int'(($realtime - t0) / 100.0)), 16'h0010 << r);
      wait_stat(8'h80, 8'h00);
    end
    chk(16'(stops), 16'h0005);
    chk(16'(nbytes), 16'h0009);
    // A refused address stops the transfer and drops the queued bytes.
    wr(8'h9a, 8'h66);
    wr(8'h9a, 8'h77);
    nack = 1'b1;
    wr(8'he8, 8'h80);
    wr(8'he9, 8'ha0);
    wait_stat(8'h80, 8'h00);
    nack = 1'b0;
    rdchk(8'hea, 8'hcc, 8'h40);
    chk(16'(nbytes), 16'h000a);
    wr(8'hea, 8'h00);
    rdchk(8'hea, 8'h40, 8'h00);
    // Write and read in one cycle: both are dropped and flagged.
    @(negedge clk_i);
    sfr = '{wr: 1'b1, rd: 1'b1, addr: 8'he8, wdata: 8'h00};
    @(negedge clk_i);
    sfr = '0;
    rdchk(8'hea, 8'h02, 8'h02);
    rdchk(8'he8, 8'hff, 8'h80);
    wr(8'hea, 8'h00);
    rdchk(8'hea, 8'hff, 8'h00);
    // Five-byte read: the receive FIFO fills mid-transfer and is popped before the fifth byte arrives.
    wr(8'he8, 8'h84);
    wr(8'he9, 8'ha1);
    wait_stat(8'h0c, 8'h0c);
    rdchk(8'hea, 8'hac, 8'hac);
    rdchk(8'h9b, 8'hff, 8'h5a);
    wait_stat(8'h80, 8'h00);
    for (int k = 1; k < 5; k++) begin
      rdchk(8'h9b, 8'hff, 8'(8'h5a + k));
    end
    rdchk(8'h9b, 8'hff, 8'h00);
    chk(16'(last), 16'h00a1);
    chk(16'(hist), 16'h0001);
    chk(16'(irq), 16'h0001);
    wr(8'hea, 8'h00);
    rdchk(8'hea, 8'h20, 8'h00);
    // A new address mid-transfer turns the stop into a repeated start.
    s0 = starts;
    p0 = stops;
    wr(8'he8, 8'h80);
    wr(8'h9a, 8'h99);
    wr(8'he9, 8'ha0);
    // Rewrite only once the first address is latched and bits are moving.
    @(posedge scl_w);
    @(posedge scl_w);
    wr(8'he9, 8'ha2);
    wait_stat(8'h80, 8'h00);
    chk(16'(8'(starts - s0)), 16'h0002);
    chk(16'(8'(stops - p0)), 16'h0001);
    chk(16'(last), 16'h00a2);
    finish_test();
  end
endmodule : tb

`default_nettype wire
